// ==== hw/rcc_pkg.sv ====
// Constants and carrier types for the rate converter configuration bank.
// Assumes one clock domain and a byte-wide internal register port.
package rcc_pkg;

  // Register offsets on the control port
  localparam logic [7:0] ADDR_CONTROL     = 8'h17;
  localparam logic [7:0] ADDR_RATIO       = 8'h18;

  // Values after reset
  localparam logic [7:0] RESET_CONTROL    = 8'h00;
  localparam logic [7:0] RESET_RATIO      = 8'h00;

  // Field positions, control register
  localparam int         BIT_CONV_ENABLE  = 7;
  localparam int         BIT_AUTO_DISABLE = 6;
  localparam logic [7:0] CONTROL_WMASK    = 8'hC0;

  // Field positions, ratio setup register
  localparam int         BIT_MAIN_MANUAL  = 7;
  localparam int         BIT_MAIN_SOURCE  = 6;
  localparam int         TERM_M_LSB       = 3;
  localparam int         TERM_N_LSB       = 0;
  localparam int         TERM_WIDTH       = 3;

  // Ratio term codes
  localparam logic [2:0] CODE_INFER       = 3'h0;
  localparam logic [2:0] CODE_FOUR        = 3'h4;
  localparam logic [2:0] CODE_RESERVED    = 3'h5;
  localparam logic [2:0] CODE_SIX         = 3'h6;
  localparam logic [2:0] CODE_UNDEFINED   = 3'h7;

  // Answer to an unmapped read
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;

  // Decoded ratio term
  typedef struct packed {
    logic [2:0] value;
    logic       inferred;
    logic       reserved;
  } rcc_ratio_type;

  // Decoded converter mode
  typedef struct packed {
    logic rate_conv_enable;
    logic auto_detect_active;
    logic main_rate_manual;
    logic main_rate_source;
  } rcc_mode_type;

endpackage

// ==== hw/rcc_ratio_dec.sv ====
// Registered decoder for one ratio term code.
// Assumes the code comes from a register on the same clock.
`timescale 1ns/1ps

module rcc_ratio_dec (
  // Clock, reset, enable
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  ce_i,
  // Stored code
  input  wire logic [2:0]            code_i,
  // Decoded term
  output rcc_pkg::rcc_ratio_type     ratio_o
);

  rcc_pkg::rcc_ratio_type next_ratio;

  // Codes 1 to 4 and 6 are direct; 0 infers; 5 and 7 fall back to infer
  always_comb begin
    next_ratio = '0;
    if (code_i == rcc_pkg::CODE_INFER) begin
      next_ratio.inferred = 1'b1;
    end else if (code_i <= rcc_pkg::CODE_FOUR ||
                 code_i == rcc_pkg::CODE_SIX) begin
      next_ratio.value = code_i;
    end else begin
      next_ratio.inferred = 1'b1;
      next_ratio.reserved = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ratio_o <= '{value: 3'h0, inferred: 1'b1, reserved: 1'b0};
    end else if (ce_i) begin
      ratio_o <= next_ratio;
    end
  end

endmodule

// ==== hw/rcc_regs.sv ====
// Rate converter configuration bank: two byte registers and their decode.
// Assumes a byte-wide register port clocked by clk_i, one access a cycle.
//
// Operation
// - Control bit 7 set turns the rate converter on, clear keeps it off.
// - Control bit 6 clear keeps automatic rate detection on; set turns it off.
// - Ratio bit 7 clear infers main rate; set takes it from the source bit.
// - Ratio bit 6 picks primary (0) or secondary (1) serial port frame rate.
// - Bits 5-3 give term m: 0 infers, 1-4 and 6 direct, 5 reserved.
// - Bits 2-0 give term n: 0 infers, 1-4 and 6 direct, 5 reserved.
// - Control bits 5-0 read zero; software writes only zero there.
// - Both registers hold 0x00 after reset: off, auto detect, all inferred.
`timescale 1ns/1ps

module rcc_regs (
  // Clock, reset, enable
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  ce_i,
  // Register port
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  output logic      [7:0]            reg_rdata_o,
  output logic                       reg_rvalid_o,
  // Decoded configuration
  output rcc_pkg::rcc_mode_type      mode_o,
  output rcc_pkg::rcc_ratio_type     ratio_m_o,
  output rcc_pkg::rcc_ratio_type     ratio_n_o
);

  logic [7:0] control;
  logic [7:0] ratio_setup;
  logic [7:0] next_rdata;
  logic       wr_control;
  logic       wr_ratio;

  assign wr_control = ce_i && reg_wr_i && reg_addr_i == rcc_pkg::ADDR_CONTROL;
  assign wr_ratio   = ce_i && reg_wr_i && reg_addr_i == rcc_pkg::ADDR_RATIO;

  // Control register; reserved bits never store
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      control <= rcc_pkg::RESET_CONTROL;
    end else if (wr_control) begin
      control <= reg_wdata_i & rcc_pkg::CONTROL_WMASK;
    end
  end

  // Ratio setup register; all bits stored as written
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ratio_setup <= rcc_pkg::RESET_RATIO;
    end else if (wr_ratio) begin
      ratio_setup <= reg_wdata_i;
    end
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    case (reg_addr_i)
      rcc_pkg::ADDR_CONTROL: next_rdata = control;
      rcc_pkg::ADDR_RATIO:   next_rdata = ratio_setup;
      default:               next_rdata = rcc_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // Converter mode decode
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_o <= '{rate_conv_enable:   1'b0,
                  auto_detect_active: 1'b1,
                  main_rate_manual:   1'b0,
                  main_rate_source:   1'b0};
    end else if (ce_i) begin
      mode_o.rate_conv_enable   <= control[rcc_pkg::BIT_CONV_ENABLE];
      mode_o.auto_detect_active <= ~control[rcc_pkg::BIT_AUTO_DISABLE];
      mode_o.main_rate_manual   <=
        ratio_setup[rcc_pkg::BIT_MAIN_MANUAL];
      mode_o.main_rate_source   <=
        ratio_setup[rcc_pkg::BIT_MAIN_MANUAL] &
        ratio_setup[rcc_pkg::BIT_MAIN_SOURCE];
    end
  end

  // Ratio term decode, m then n
  rcc_ratio_dec u_dec_m (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .code_i  (ratio_setup[rcc_pkg::TERM_M_LSB +: rcc_pkg::TERM_WIDTH]),
    .ratio_o (ratio_m_o)
  );

  rcc_ratio_dec u_dec_n (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .code_i  (ratio_setup[rcc_pkg::TERM_N_LSB +: rcc_pkg::TERM_WIDTH]),
    .ratio_o (ratio_n_o)
  );

  // Checks
  a_control_reset: assert property (@(posedge clk_i)
    srst_i |=> control == 8'h00 && ratio_setup == 8'h00 &&
               !mode_o.rate_conv_enable && mode_o.auto_detect_active &&
               ratio_m_o.inferred && ratio_n_o.inferred)
    else $error("reset values wrong");

  a_reserved_zero: assert property (@(posedge clk_i)
    disable iff (srst_i)
    ce_i && reg_rd_i && reg_addr_i == rcc_pkg::ADDR_CONTROL
    |=> reg_rdata_o[5:0] == 6'h00)
    else $error("control reserved bits read nonzero");

  a_enable_follow: assert property (@(posedge clk_i)
    disable iff (srst_i)
    wr_control ##1 ce_i |=> mode_o.rate_conv_enable == $past(control[7]))
    else $error("converter enable does not follow register");

  a_auto_detect: assert property (@(posedge clk_i)
    disable iff (srst_i)
    wr_control && reg_wdata_i[6] ##1 ce_i |=> !mode_o.auto_detect_active)
    else $error("auto detect not disabled");

  a_main_manual: assert property (@(posedge clk_i)
    disable iff (srst_i)
    wr_ratio ##1 ce_i |=> mode_o.main_rate_manual == $past(reg_wdata_i[7], 2))
    else $error("main rate manual flag wrong");

  a_source_gated: assert property (@(posedge clk_i)
    disable iff (srst_i)
    !mode_o.main_rate_manual |-> !mode_o.main_rate_source)
    else $error("source bit passed while inferred");

  a_m_direct: assert property (@(posedge clk_i)
    disable iff (srst_i)
    wr_ratio && reg_wdata_i[5:3] == 3'h6 ##1 ce_i
    |=> ratio_m_o.value == 3'h6 && !ratio_m_o.inferred)
    else $error("term m direct code not decoded");

  a_n_reserved: assert property (@(posedge clk_i)
    disable iff (srst_i)
    wr_ratio && reg_wdata_i[2:0] == 3'h5 ##1 ce_i
    |=> ratio_n_o.reserved && ratio_n_o.inferred && ratio_n_o.value == 3'h0)
    else $error("term n reserved code not flagged");

  a_code_seven: assert property (@(posedge clk_i)
    disable iff (srst_i)
    wr_ratio && reg_wdata_i[5:3] == 3'h7 ##1 ce_i
    |=> ratio_m_o.reserved && ratio_m_o.value == 3'h0)
    else $error("undefined code not treated as reserved");

  a_read_answer: assert property (@(posedge clk_i)
    disable iff (srst_i)
    ce_i && reg_rd_i && reg_addr_i == 8'h18 && !wr_ratio
    |=> reg_rvalid_o && reg_rdata_o == $past(ratio_setup))
    else $error("ratio register read back wrong");

  a_source_select: assert property (@(posedge clk_i)
    disable iff (srst_i)
    wr_ratio && reg_wdata_i[7] ##1 ce_i
    |=> mode_o.main_rate_source == $past(reg_wdata_i[6], 2))
    else $error("main rate source not taken from register");

  a_freeze_hold: assert property (@(posedge clk_i)
    disable iff (srst_i)
    !ce_i |=> $stable(mode_o) && $stable(control) && $stable(ratio_setup))
    else $error("state moved while clock enable low");

  a_control_store: assert property (@(posedge clk_i)
    disable iff (srst_i)
    control[5:0] == 6'h00)
    else $error("control reserved bits stored nonzero");

  a_n_direct: assert property (@(posedge clk_i)
    disable iff (srst_i)
    wr_ratio && reg_wdata_i[2:0] == 3'h3 ##1 ce_i
    |=> ratio_n_o.value == 3'h3 && !ratio_n_o.reserved)
    else $error("term n direct code not decoded");

  a_m_infer: assert property (@(posedge clk_i)
    disable iff (srst_i)
    wr_ratio && reg_wdata_i[5:3] == 3'h0 ##1 ce_i
    |=> ratio_m_o.inferred && ratio_m_o.value == 3'h0 &&
        !ratio_m_o.reserved)
    else $error("term m infer code not decoded");

  a_m_reserved: assert property (@(posedge clk_i)
    disable iff (srst_i)
    wr_ratio && reg_wdata_i[5:3] == 3'h5 ##1 ce_i
    |=> ratio_m_o.reserved && ratio_m_o.inferred)
    else $error("term m reserved code not flagged");

  a_n_seven: assert property (@(posedge clk_i)
    disable iff (srst_i)
    wr_ratio && reg_wdata_i[2:0] == 3'h7 ##1 ce_i
    |=> ratio_n_o.reserved && ratio_n_o.value == 3'h0)
    else $error("term n undefined code not treated as reserved");

  c_enable_on: cover property (@(posedge clk_i)
    wr_control && reg_wdata_i[7] ##2 mode_o.rate_conv_enable);
  c_secondary: cover property (@(posedge clk_i)
    mode_o.main_rate_manual && mode_o.main_rate_source);
  c_reserved_m: cover property (@(posedge clk_i) ratio_m_o.reserved);
  c_unmapped: cover property (@(posedge clk_i)
    ce_i && reg_rd_i && reg_addr_i == 8'h20);
  c_frozen: cover property (@(posedge clk_i)
    !ce_i && reg_wr_i);

endmodule

// ==== tb/rcc_regs_tb.sv ====
// Self-checking bench for the rate converter configuration bank.
// Assumes rcc_pkg and rcc_regs are compiled first; one 100 MHz clock.
`timescale 1ns/1ps

module rcc_regs_tb;
  logic                   clk_i       = 1'b0;
  logic                   srst_i      = 1'b1;
  logic                   ce_i        = 1'b1;
  logic                   reg_wr_i    = 1'b0;
  logic                   reg_rd_i    = 1'b0;
  logic [7:0]             reg_addr_i  = 8'h00;
  logic [7:0]             reg_wdata_i = 8'h00;
  logic [7:0]             reg_rdata_o;
  logic                   reg_rvalid_o;
  rcc_pkg::rcc_mode_type  mode_o;
  rcc_pkg::rcc_ratio_type ratio_m_o;
  rcc_pkg::rcc_ratio_type ratio_n_o;
  int                     n_mismatch  = 0;
  int                     n_tests     = 0;
  int                     cycles      = 0;

  always #5 clk_i = ~clk_i;

  rcc_regs rcc_regs_i (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .mode_o(mode_o),
    .ratio_m_o(ratio_m_o), .ratio_n_o(ratio_n_o)
  );

  task automatic conclude();
    $display("Compares %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write strobe taken at the next edge; decoded outputs settle one later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk({what, " rvalid"}, 8'h01, {7'h00, reg_rvalid_o});
    chk(what, exp, reg_rdata_o);
  endtask

  // Decoded term: {value, inferred, reserved}
  function automatic logic [7:0] exp_ratio(input logic [2:0] c);
    if (c == 3'h5 || c == 3'h7) return 8'h03;
    if (c == 3'h0) return 8'h02;
    return {3'h0, c, 2'b00};
  endfunction

  task automatic t_reset();
    rd_chk("control", 8'h17, 8'h00);
    rd_chk("ratio", 8'h18, 8'h00);
    chk("mode", 8'h04, {4'h0, mode_o});
    chk("term m", 8'h02, {3'h0, ratio_m_o});
    chk("term n", 8'h02, {3'h0, ratio_n_o});
  endtask

  // Reserved control bits are only ever written as zero
  task automatic t_control();
    logic [7:0] pat [4] = '{8'hC0, 8'h80, 8'h40, 8'h00};
    logic [7:0] exp_mode;
    foreach (pat[i]) begin
      exp_mode = {4'h0, pat[i][7], ~pat[i][6], 2'b00};
      wr(8'h17, pat[i]);
      rd_chk("control", 8'h17, pat[i] & 8'hC0);
      chk("mode", exp_mode, {4'h0, mode_o});
    end
  endtask

  task automatic t_source();
    logic [7:0] exp_mode;
    for (int s = 0; s < 4; s++) begin
      exp_mode = {6'h01, s[1], s[1] & s[0]};
      wr(8'h18, {s[1:0], 6'h00});
      chk("mode", exp_mode, {4'h0, mode_o});
    end
  endtask

  task automatic t_codes();
    logic [2:0] m;
    logic [2:0] n;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      n = 3'(7 - i);
      wr(8'h18, {2'b00, m, n});
      rd_chk("ratio", 8'h18, {2'b00, m, n});
      chk("term m", exp_ratio(m), {3'h0, ratio_m_o});
      chk("term n", exp_ratio(n), {3'h0, ratio_n_o});
    end
  endtask

  task automatic t_unmapped_and_freeze();
    wr(8'h19, 8'hFF);
    rd_chk("unmapped", 8'h19, 8'h00);
    rd_chk("ratio", 8'h18, 8'h38);
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(8'h17, 8'h80);
    chk("frozen mode", 8'h04, {4'h0, mode_o});
    @(posedge clk_i);
    ce_i <= 1'b1;
    rd_chk("control", 8'h17, 8'h00);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_control();
    t_source();
    t_codes();
    t_unmapped_and_freeze();
    wr(8'h17, 8'hC0);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    conclude();
  end
endmodule
